// file: src/tkc_touch_key_ctrl.sv
// Purpose: dual-slope touch key conversion sequencer with apb registers
// Assumes: apb master runs on ref_clk; comparator output and slow oscillator are asynchronous
// Notes: apb answers with one wait state
//
// What this block does
// - clearing enable idles and clears converter
// - clock select picks divided system/slow clock
// - guard enable drives guard buffer enable
// - interrupt at end of whole sequence
// - auto threshold gives interrupt and wakeup
// - interrupt generation sets interrupt flag
// - low power bit sets comparator low power
// - auto compares duty against absolute/relative threshold
// - start bit begins one normal sequence
// - repeat field gives 1/4/8/16 cycles
// - settling delay (n+1)*4 touch clocks
// - auto start idle (n+1)*256 touch clocks
// - filter ignores constant level beyond n*8
// - cycle counter runs while filter rejects
// - first comparator edges are discarded
// - high/low times accumulate across sequence
// - equalize before and after each sequence
// - pseudo-random charge/discharge timing option
// - baseline keeps slow moving duty average
// - alternating charge and discharge phases
// - relative select adds baseline to threshold
// - start self-clears, busy shows running
// - sequence length 1024 to 65536 cycles
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`include "tkc_map.svh"

module tkc_touch_key_ctrl (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`TKC_APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cmpOut,
    input wire logic slowOsc,
    output logic convEnable,
    output logic guardDriveEn,
    output logic lowPowerCmp,
    output logic equalizeOn,
    output logic chargePhase,
    output logic [2:0] chargeCapSel,
    output logic irq,
    output logic wakeup
);
    import tkc_pkg::*;

    tkc_state_type state_q;
    logic [7:0] ctrlA_q, timingB_q, ctrlC_q;
    logic [2:0] capSel_q;
    logic delayEn_q, randEn_q, nfFlag_q, irqFlag_q, start_q;
    logic [15:0] highDuty_q, lowDuty_q, base_q, thr_q;
    logic [1:0] syncIn [3];
    logic [1:0] inLvl_q, inPrev_q;
    logic [4:0] divCnt_q;
    logic slowHalf_q, tick_q;
    logic [15:0] phaseCnt_q, lfsr_q;
    logic [4:0] repCnt_q, runCnt_q;
    logic [1:0] edgeCnt_q;
    logic firstAuto_q, prevCmp_q;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q, convEnable_q, guard_q, lowPower_q, equalize_q;
    logic chargePhase_q, irq_q, wakeup_q;

    // decoded fields
    logic enable, autoMode, irqEn, relSel, baseIni, autoNf;
    logic [2:0] clkSel, lenSel;
    logic [1:0] rptSel, settleSel, sleepSel, nfSel, slowSel;
    assign enable = ctrlA_q[`TKC_A_ENABLE];
    assign autoMode = ctrlA_q[`TKC_A_AUTO];
    assign irqEn = ctrlA_q[`TKC_A_IRQEN];
    assign clkSel = ctrlA_q[`TKC_A_CLKSEL_HI:`TKC_A_CLKSEL_LO];
    assign rptSel = timingB_q[`TKC_B_RPT_HI:`TKC_B_RPT_LO];
    assign settleSel = timingB_q[`TKC_B_SETTLE_HI:`TKC_B_SETTLE_LO];
    assign sleepSel = timingB_q[`TKC_B_SLEEP_HI:`TKC_B_SLEEP_LO];
    assign nfSel = timingB_q[`TKC_B_NF_HI:`TKC_B_NF_LO];
    assign slowSel = ctrlC_q[`TKC_C_SLOW_HI:`TKC_C_SLOW_LO];
    assign lenSel = ctrlC_q[`TKC_C_LEN_HI:`TKC_C_LEN_LO];
    assign baseIni = ctrlC_q[`TKC_C_BASEINI];
    assign relSel = ctrlC_q[`TKC_C_THRREL];
    assign autoNf = ctrlC_q[`TKC_C_AUTONF];

    // apb decode: one wait state so read data comes from a flop
    logic [`TKC_IDX_W-1:0] idx;
    logic wrDone, accPhase, mapped;
    assign idx = paddr[`TKC_APB_AW-1:2];
    assign accPhase = psel && penable;
    assign wrDone = accPhase && pready_q && pwrite && !pslverr_q;
    always_comb begin
        mapped = (paddr[1:0] == 2'h0);
        case (idx)
            `TKC_IDX_CTRL_A, `TKC_IDX_TIMING_B, `TKC_IDX_CTRL_C, `TKC_IDX_CTRL_D,
            `TKC_IDX_HIGH_L, `TKC_IDX_HIGH_H, `TKC_IDX_LOW_L, `TKC_IDX_LOW_H,
            `TKC_IDX_BASE_L, `TKC_IDX_BASE_H, `TKC_IDX_THR_L, `TKC_IDX_THR_H: begin
            end
            default: mapped = 1'b0;
        endcase
    end

    logic [7:0] rdByte;
    always_comb begin
        case (idx)
            `TKC_IDX_CTRL_A: rdByte = ctrlA_q;
            `TKC_IDX_TIMING_B: rdByte = timingB_q;
            `TKC_IDX_CTRL_C: rdByte = ctrlC_q;
            `TKC_IDX_CTRL_D: rdByte = {capSel_q, delayEn_q, randEn_q, nfFlag_q, irqFlag_q,
                                        state_q != TKC_IDLE};
            `TKC_IDX_HIGH_L: rdByte = highDuty_q[7:0];
            `TKC_IDX_HIGH_H: rdByte = highDuty_q[15:8];
            `TKC_IDX_LOW_L: rdByte = lowDuty_q[7:0];
            `TKC_IDX_LOW_H: rdByte = lowDuty_q[15:8];
            `TKC_IDX_BASE_L: rdByte = base_q[7:0];
            `TKC_IDX_BASE_H: rdByte = base_q[15:8];
            `TKC_IDX_THR_L: rdByte = thr_q[7:0];
            `TKC_IDX_THR_H: rdByte = thr_q[15:8];
            default: rdByte = `TKC_RST_BYTE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= accPhase && !pready_q;
            pslverr_q <= accPhase && !pready_q && !mapped;
            if (accPhase && !pready_q)
                prdata_q <= {24'h00_0000, (mapped && !pwrite) ? rdByte : `TKC_RST_BYTE};
        end
    end

    // plain software registers
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrlA_q <= `TKC_RST_BYTE;
            timingB_q <= `TKC_RST_BYTE;
            ctrlC_q <= `TKC_RST_BYTE;
            capSel_q <= 3'h0;
            delayEn_q <= 1'b0;
            randEn_q <= 1'b0;
            thr_q <= 16'h0000;
        end else if (wrDone) begin
            case (idx)
                `TKC_IDX_CTRL_A: ctrlA_q <= pwdata[7:0];
                `TKC_IDX_TIMING_B: timingB_q <= pwdata[7:0];
                `TKC_IDX_CTRL_C: ctrlC_q <= pwdata[7:0];
                `TKC_IDX_CTRL_D: begin
                    capSel_q <= pwdata[`TKC_D_CAP_HI:`TKC_D_CAP_LO];
                    delayEn_q <= pwdata[`TKC_D_SDLYEN];
                    randEn_q <= pwdata[`TKC_D_RANDEN];
                end
                `TKC_IDX_THR_L: thr_q[7:0] <= pwdata[7:0];
                `TKC_IDX_THR_H: thr_q[15:8] <= pwdata[7:0];
                default: begin
                end
            endcase
        end
    end

    // async inputs: three flops, a change counts once stages two and three agree
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gSync
            always_ff @(posedge ref_clk or negedge rst_b) begin
                if (!rst_b) begin
                    syncIn[0][g] <= 1'b0;
                    syncIn[1][g] <= 1'b0;
                    syncIn[2][g] <= 1'b0;
                    inLvl_q[g] <= 1'b0;
                    inPrev_q[g] <= 1'b0;
                end else begin
                    syncIn[0][g] <= (g == 0) ? cmpOut : slowOsc;
                    syncIn[1][g] <= syncIn[0][g];
                    syncIn[2][g] <= syncIn[1][g];
                    if (syncIn[1][g] == syncIn[2][g])
                        inLvl_q[g] <= syncIn[2][g];
                    inPrev_q[g] <= inLvl_q[g];
                end
            end
        end
    endgenerate

    logic cmpLvl, slowRise;
    assign cmpLvl = inLvl_q[0];
    assign slowRise = inLvl_q[1] && !inPrev_q[1];

    // touch clock as a one-cycle tick
    logic [4:0] divM1;
    always_comb begin
        case (clkSel)
            3'h0: divM1 = `TKC_DIV0_M1;
            3'h1: divM1 = `TKC_DIV1_M1;
            3'h2: divM1 = `TKC_DIV2_M1;
            3'h3: divM1 = `TKC_DIV3_M1;
            3'h4: divM1 = `TKC_DIV4_M1;
            3'h5: divM1 = `TKC_DIV5_M1;
            default: divM1 = `TKC_DIV6_M1;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            divCnt_q <= 5'h00;
            slowHalf_q <= 1'b0;
            tick_q <= 1'b0;
        end else if (!enable) begin
            divCnt_q <= 5'h00;
            slowHalf_q <= 1'b0;
            tick_q <= 1'b0;
        end else if (clkSel == `TKC_CLKSEL_SLOW) begin
            if (slowRise)
                slowHalf_q <= !slowHalf_q;
            tick_q <= slowRise && slowHalf_q;
            divCnt_q <= 5'h00;
        end else begin
            tick_q <= (divCnt_q >= divM1);
            divCnt_q <= (divCnt_q >= divM1) ? 5'h00 : divCnt_q + 5'h01;
        end
    end

    // sequence targets
    logic [15:0] lenM1, settleM1, sleepM1;
    logic [4:0] rptTarget, nfLimit;
    always_comb begin
        case (lenSel)
            3'h0: lenM1 = `TKC_LEN0_M1;
            3'h1: lenM1 = `TKC_LEN1_M1;
            3'h2: lenM1 = `TKC_LEN2_M1;
            3'h3: lenM1 = `TKC_LEN3_M1;
            3'h4: lenM1 = `TKC_LEN4_M1;
            3'h5: lenM1 = `TKC_LEN5_M1;
            3'h6: lenM1 = `TKC_LEN6_M1;
            default: lenM1 = `TKC_LEN7_M1;
        endcase
        case (rptSel)
            2'h0: rptTarget = `TKC_RPT0;
            2'h1: rptTarget = `TKC_RPT1;
            2'h2: rptTarget = `TKC_RPT2;
            default: rptTarget = `TKC_RPT3;
        endcase
    end
    assign settleM1 = ({14'h0000, settleSel} + 16'h0001) * 16'(1 << `TKC_SETTLE_SHIFT)
                      - 16'h0001;
    assign sleepM1 = ({14'h0000, sleepSel} + 16'h0001) * 16'(1 << `TKC_SLEEP_SHIFT)
                     - 16'h0001;
    assign nfLimit = 5'({nfSel, 3'h0});

    // noise filter and edge discard
    logic nfOn, nfHit, reject, cmpEdge, accumOk;
    assign cmpEdge = cmpLvl != prevCmp_q;
    assign nfHit = (nfSel != 2'h0) && (runCnt_q >= nfLimit);
    assign nfOn = !autoMode || autoNf;
    assign reject = nfOn && nfHit;
    assign accumOk = (edgeCnt_q == `TKC_DISCARD_EDGES) && !reject;

    // auto threshold and baseline
    logic [16:0] thrEff;
    logic wakeHit;
    logic signed [16:0] baseDiff, baseStep;
    assign thrEff = relSel ? {1'b0, thr_q} + {1'b0, base_q} : {1'b0, thr_q};
    assign wakeHit = {1'b0, lowDuty_q} > thrEff;
    assign baseDiff = $signed({1'b0, lowDuty_q}) - $signed({1'b0, base_q});
    assign baseStep = baseDiff >>> (`TKC_AVG_BASE_SHIFT + slowSel);

    logic seqStart, lastCycle, finishNow;
    assign seqStart = (state_q == TKC_IDLE) && enable && (autoMode || start_q);
    assign lastCycle = (phaseCnt_q == lenM1) && (repCnt_q == rptTarget - 5'h01);
    assign finishNow = state_q == TKC_FINISH;

    // sequencer
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= TKC_IDLE;
            phaseCnt_q <= 16'h0000;
            repCnt_q <= 5'h00;
        end else if (!enable) begin
            state_q <= TKC_IDLE;
            phaseCnt_q <= 16'h0000;
            repCnt_q <= 5'h00;
        end else begin
            case (state_q)
                TKC_IDLE: begin
                    phaseCnt_q <= 16'h0000;
                    repCnt_q <= 5'h00;
                    if (seqStart)
                        state_q <= (autoMode && delayEn_q) ? TKC_SLEEP_DLY : TKC_SETTLE;
                end
                TKC_SLEEP_DLY, TKC_SETTLE: begin
                    if (tick_q) begin
                        if (phaseCnt_q == ((state_q == TKC_SETTLE) ? settleM1 : sleepM1)) begin
                            phaseCnt_q <= 16'h0000;
                            state_q <= (state_q == TKC_SETTLE) ? TKC_COUNT : TKC_SETTLE;
                        end else begin
                            phaseCnt_q <= phaseCnt_q + 16'h0001;
                        end
                    end
                end
                TKC_COUNT: begin
                    // the cycle counter ignores the filter, so duty sums may fall short
                    if (tick_q) begin
                        if (lastCycle) begin
                            state_q <= TKC_FINISH;
                        end else if (phaseCnt_q == lenM1) begin
                            phaseCnt_q <= 16'h0000;
                            repCnt_q <= repCnt_q + 5'h01;
                        end else begin
                            phaseCnt_q <= phaseCnt_q + 16'h0001;
                        end
                    end
                end
                TKC_FINISH: state_q <= TKC_IDLE;
                default: state_q <= TKC_IDLE;
            endcase
        end
    end

    // accumulation, filter run length, random sequence
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            highDuty_q <= 16'h0000;
            lowDuty_q <= 16'h0000;
            runCnt_q <= 5'h00;
            edgeCnt_q <= 2'h0;
            prevCmp_q <= 1'b0;
            lfsr_q <= `TKC_LFSR_SEED;
            chargePhase_q <= 1'b0;
        end else if (!enable || seqStart) begin
            highDuty_q <= 16'h0000;
            lowDuty_q <= 16'h0000;
            runCnt_q <= 5'h00;
            edgeCnt_q <= 2'h0;
            prevCmp_q <= cmpLvl;
            lfsr_q <= `TKC_LFSR_SEED;
            chargePhase_q <= 1'b0;
        end else if (tick_q && (state_q == TKC_SETTLE || state_q == TKC_COUNT)) begin
            lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
            chargePhase_q <= randEn_q ? lfsr_q[15] : !chargePhase_q;
            if (state_q == TKC_COUNT) begin
                prevCmp_q <= cmpLvl;
                if (cmpEdge && edgeCnt_q != `TKC_DISCARD_EDGES)
                    edgeCnt_q <= edgeCnt_q + 2'h1;
                runCnt_q <= cmpEdge ? 5'h00 : (runCnt_q == 5'h1f ? runCnt_q : runCnt_q + 5'h01);
                if (accumOk) begin
                    if (cmpLvl && highDuty_q != `TKC_DUTY_MAX)
                        highDuty_q <= highDuty_q + 16'h0001;
                    if (!cmpLvl && lowDuty_q != `TKC_DUTY_MAX)
                        lowDuty_q <= lowDuty_q + 16'h0001;
                end
            end
        end
    end

    // flags: hardware set wins over a software clear; start bit: hardware clear wins over a software set
    logic wrD;
    assign wrD = wrDone && idx == `TKC_IDX_CTRL_D;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            irqFlag_q <= 1'b0;
            nfFlag_q <= 1'b0;
            start_q <= 1'b0;
        end else begin
            if (finishNow && irqEn && (!autoMode || wakeHit))
                irqFlag_q <= 1'b1;
            else if (wrD && !pwdata[`TKC_D_IRQFLAG])
                irqFlag_q <= 1'b0;
            if (state_q == TKC_COUNT && tick_q && nfHit)
                nfFlag_q <= 1'b1;
            else if (wrD && !pwdata[`TKC_D_NFFLAG])
                nfFlag_q <= 1'b0;
            if (!enable || (finishNow && !autoMode))
                start_q <= 1'b0;
            else if (wrD && pwdata[`TKC_D_START] && !autoMode)
                start_q <= 1'b1;
        end
    end

    // baseline average; software may seed it
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            base_q <= 16'h0000;
            firstAuto_q <= 1'b1;
        end else begin
            if (!autoMode || !enable)
                firstAuto_q <= 1'b1;
            else if (finishNow)
                firstAuto_q <= 1'b0;
            if (wrDone && idx == `TKC_IDX_BASE_L)
                base_q[7:0] <= pwdata[7:0];
            else if (wrDone && idx == `TKC_IDX_BASE_H)
                base_q[15:8] <= pwdata[7:0];
            else if (finishNow && autoMode)
                base_q <= (firstAuto_q && baseIni) ? lowDuty_q
                          : 16'($signed({1'b0, base_q}) + baseStep);
        end
    end

    // analog controls and outputs, all from flops
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            convEnable_q <= 1'b0;
            guard_q <= 1'b0;
            lowPower_q <= 1'b0;
            equalize_q <= 1'b0;
            irq_q <= 1'b0;
            wakeup_q <= 1'b0;
        end else begin
            convEnable_q <= enable;
            guard_q <= enable && ctrlA_q[`TKC_A_GUARD];
            lowPower_q <= enable && ctrlA_q[`TKC_A_LOWPWR];
            equalize_q <= enable && state_q != TKC_COUNT;
            irq_q <= irqFlag_q && irqEn;
            wakeup_q <= finishNow && autoMode && irqEn && wakeHit;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign convEnable = convEnable_q;
    assign guardDriveEn = guard_q;
    assign lowPowerCmp = lowPower_q;
    assign equalizeOn = equalize_q;
    assign chargePhase = chargePhase_q;
    assign chargeCapSel = capSel_q;
    assign irq = irq_q;
    assign wakeup = wakeup_q;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    a_disable_idles: assert property (!enable |=> state_q == TKC_IDLE && !convEnable_q)
        else $error("converter not idle after disable");
    a_tick_spacing: assert property (tick_q |=> !tick_q)
        else $error("touch clock ticks back to back");
    a_normal_flag: assert property (finishNow && irqEn && !autoMode |=> irqFlag_q ##1 irq_q)
        else $error("no interrupt after normal sequence");
    a_auto_wake: assert property (finishNow && autoMode && irqEn && wakeHit
                                  |=> wakeup_q && irqFlag_q)
        else $error("auto hit without wakeup");
    a_wake_cause: assert property (wakeup_q |-> $past(finishNow) && $past(autoMode) && $past(wakeHit))
        else $error("wakeup without threshold hit");
    a_start_clears: assert property (finishNow && !autoMode |=> !start_q && state_q == TKC_IDLE)
        else $error("start bit not cleared at completion");
    a_repeat_total: assert property (state_q == TKC_COUNT ##1 state_q == TKC_FINISH
                                     |-> $past(repCnt_q) == rptTarget - 5'h01)
        else $error("wrong repeat count at finish");
    a_settle_len: assert property (state_q == TKC_SETTLE ##1 state_q == TKC_COUNT
                                   |-> $past(phaseCnt_q) == settleM1)
        else $error("settling delay length wrong");
    a_equalize_out: assert property (state_q == TKC_COUNT |=> !equalize_q)
        else $error("equalize active while counting");
    a_flag_sticky: assert property (irqFlag_q && !wrD |=> irqFlag_q)
        else $error("flag cleared without a write");
    a_irq_level: assert property (irqFlag_q && irqEn |=> irq_q)
        else $error("irq output missing");

    c_normal_done: cover property (finishNow && !autoMode);
    c_auto_wake: cover property (wakeup_q);
    c_noise_seen: cover property (nfFlag_q && state_q == TKC_COUNT);
endmodule

// file: src/tkc_map.svh
// Purpose: register indices, field positions, reset values and timing constants
// Assumes: byte address of a register is four times its index
// Notes: definitions only
`ifndef TKC_MAP_SVH
`define TKC_MAP_SVH

`define TKC_APB_AW 20
`define TKC_IDX_W 18
`define TKC_IDX_CTRL_A 18'h0a018
`define TKC_IDX_TIMING_B 18'h0a019
`define TKC_IDX_CTRL_C 18'h0a01a
`define TKC_IDX_CTRL_D 18'h0a01b
`define TKC_IDX_HIGH_L 18'h0a01c
`define TKC_IDX_HIGH_H 18'h0a01d
`define TKC_IDX_LOW_L 18'h0a01e
`define TKC_IDX_LOW_H 18'h0a01f
`define TKC_IDX_BASE_L 18'h0a028
`define TKC_IDX_BASE_H 18'h0a029
`define TKC_IDX_THR_L 18'h0a02a
`define TKC_IDX_THR_H 18'h0a02b
`define TKC_RST_BYTE 8'h00

// control a
`define TKC_A_ENABLE 7
`define TKC_A_CLKSEL_HI 6
`define TKC_A_CLKSEL_LO 4
`define TKC_A_GUARD 3
`define TKC_A_IRQEN 2
`define TKC_A_LOWPWR 1
`define TKC_A_AUTO 0
// timing b
`define TKC_B_RPT_HI 7
`define TKC_B_RPT_LO 6
`define TKC_B_SETTLE_HI 5
`define TKC_B_SETTLE_LO 4
`define TKC_B_SLEEP_HI 3
`define TKC_B_SLEEP_LO 2
`define TKC_B_NF_HI 1
`define TKC_B_NF_LO 0
// control c
`define TKC_C_SLOW_HI 7
`define TKC_C_SLOW_LO 6
`define TKC_C_LEN_HI 5
`define TKC_C_LEN_LO 3
`define TKC_C_BASEINI 2
`define TKC_C_THRREL 1
`define TKC_C_AUTONF 0
// control d
`define TKC_D_CAP_HI 7
`define TKC_D_CAP_LO 5
`define TKC_D_SDLYEN 4
`define TKC_D_RANDEN 3
`define TKC_D_NFFLAG 2
`define TKC_D_IRQFLAG 1
`define TKC_D_START 0

// touch clock divisors, minus one, for select codes 0..6
`define TKC_DIV0_M1 5'h01
`define TKC_DIV1_M1 5'h03
`define TKC_DIV2_M1 5'h05
`define TKC_DIV3_M1 5'h07
`define TKC_DIV4_M1 5'h09
`define TKC_DIV5_M1 5'h0f
`define TKC_DIV6_M1 5'h1f
`define TKC_CLKSEL_SLOW 3'h7

// sequence lengths minus one
`define TKC_LEN0_M1 16'h03ff
`define TKC_LEN1_M1 16'h07ff
`define TKC_LEN2_M1 16'h0fff
`define TKC_LEN3_M1 16'h1fff
`define TKC_LEN4_M1 16'h2fff
`define TKC_LEN5_M1 16'h3fff
`define TKC_LEN6_M1 16'h7fff
`define TKC_LEN7_M1 16'hffff

`define TKC_RPT0 5'h01
`define TKC_RPT1 5'h04
`define TKC_RPT2 5'h08
`define TKC_RPT3 5'h10
`define TKC_SETTLE_SHIFT 2
`define TKC_SLEEP_SHIFT 8
`define TKC_NF_SHIFT 3
`define TKC_AVG_BASE_SHIFT 5
`define TKC_DISCARD_EDGES 2'h2
`define TKC_LFSR_SEED 16'hace1
`define TKC_DUTY_MAX 16'hffff

`endif

// file: src/tkc_pkg.sv
// Purpose: shared types of the touch key conversion control
// Assumes: tkc_map.svh holds all numbers
// Notes: none
package tkc_pkg;
    typedef enum logic [2:0] {
        TKC_IDLE,
        TKC_SLEEP_DLY,
        TKC_SETTLE,
        TKC_COUNT,
        TKC_FINISH
    } tkc_state_type;
endpackage

// file: sim/tkc_front_end_model.sv
// Purpose: charge-transfer front end and comparator stand-in
// Assumes: comparator is forced low while disabled or equalizing
// Notes: slow oscillator runs free, unrelated to ref_clk
`timescale 1ns/1ps
module tkc_front_end_model (
    input wire logic ref_clk,
    input wire logic convEnable,
    input wire logic equalizeOn,
    input wire logic chargePhase,
    output logic cmpOut,
    output logic slowOsc
);
    logic [2:0] lvl_q;
    initial begin
        lvl_q = 3'h0;
        cmpOut = 1'b0;
        slowOsc = 1'b0;
    end
    always #80 slowOsc = ~slowOsc;
    // integrator pumps only while charging, so the comparator edges come at a steady rate
    always @(posedge ref_clk) begin
        lvl_q <= chargePhase ? lvl_q + 3'h1 : lvl_q;
        cmpOut <= convEnable & ~equalizeOn & lvl_q[2];
    end
endmodule

// file: sim/touch_key_conversion_ctrl_test.sv
// Purpose: self-checking bench of the touch key conversion control
// Assumes: one wait state apb slave, byte address is four times the index
// Notes: short settle and shortest sequence keep the run brief
`timescale 1ns/1ps
`include "tkc_map.svh"
module touch_key_conversion_ctrl_test;
    typedef struct {logic [17:0] idx; logic [7:0] wd; logic [7:0] ex; logic er;} tkc_row_type;
    logic ref_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [19:0] paddr = 20'h0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, cmpOut, slowOsc, convEnable, guardDriveEn, lowPowerCmp;
    logic equalizeOn, chargePhase, irq, wakeup, erv;
    logic [2:0] chargeCapSel;
    logic [7:0] rdv, b0, b1;
    int n_errors = 0, check_count = 0, n;
    tkc_row_type rows[6] = '{
        '{`TKC_IDX_CTRL_A, 8'h7e, 8'h7e, 1'b0}, '{`TKC_IDX_TIMING_B, 8'hff, 8'hff, 1'b0},
        '{`TKC_IDX_HIGH_L, 8'h33, 8'h00, 1'b0}, '{`TKC_IDX_THR_L, 8'h5a, 8'h5a, 1'b0},
        '{`TKC_IDX_BASE_H, 8'ha5, 8'ha5, 1'b0}, '{18'h0a020, 8'h11, 8'h00, 1'b1}};
    tkc_touch_key_ctrl uut (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmpOut(cmpOut),
        .slowOsc(slowOsc), .convEnable(convEnable), .guardDriveEn(guardDriveEn),
        .lowPowerCmp(lowPowerCmp), .equalizeOn(equalizeOn), .chargePhase(chargePhase),
        .chargeCapSel(chargeCapSel), .irq(irq), .wakeup(wakeup));
    tkc_front_end_model fe (.ref_clk(ref_clk), .convEnable(convEnable),
        .equalizeOn(equalizeOn), .chargePhase(chargePhase), .cmpOut(cmpOut),
        .slowOsc(slowOsc));
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] ex);
        check_count++;
        if (seen !== ex) begin
            n_errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, ex);
        end
    endtask
    // values read right after the edge are the ones the edge sampled
    task automatic apb(input logic [17:0] idx, input logic wr, input logic [7:0] wd);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rdv = prdata[7:0];
        erv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        test_done();
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        foreach (rows[i]) begin
            apb(rows[i].idx, 1'b1, rows[i].wd);
            apb(rows[i].idx, 1'b0, 8'h00);
            chk({8'h0, rdv}, {8'h0, rows[i].ex});
            chk({15'h0, erv}, {15'h0, rows[i].er});
        end
        chk({15'h0, guardDriveEn}, 16'h0);
        $display("register rows done");
        apb(`TKC_IDX_TIMING_B, 1'b1, 8'h00);
        apb(`TKC_IDX_CTRL_A, 1'b1, 8'h8e);
        repeat (2) @(posedge ref_clk);
        chk({13'h0, convEnable, guardDriveEn, lowPowerCmp}, 16'h7);
        chk({15'h0, equalizeOn}, 16'h1);
        apb(`TKC_IDX_CTRL_D, 1'b1, 8'h01);
        apb(`TKC_IDX_CTRL_D, 1'b0, 8'h00);
        chk({8'h0, rdv}, 16'h01);
        n = 0;
        while (irq !== 1'b1 && n < 4000) begin
            @(posedge ref_clk);
            n++;
        end
        chk(16'(n >= 2052 && n <= 2060), 16'h1);
        apb(`TKC_IDX_CTRL_D, 1'b0, 8'h00);
        chk({8'h0, rdv}, 16'h02);
        apb(`TKC_IDX_HIGH_L, 1'b0, 8'h00);
        b0 = rdv;
        apb(`TKC_IDX_LOW_L, 1'b0, 8'h00);
        b1 = rdv;
        apb(`TKC_IDX_HIGH_H, 1'b0, 8'h00);
        n = {rdv, b0};
        apb(`TKC_IDX_LOW_H, 1'b0, 8'h00);
        n = n + {rdv, b1};
        chk(16'(n > 0 && n <= 1024), 16'h1);
        apb(`TKC_IDX_CTRL_D, 1'b1, 8'h00);
        apb(`TKC_IDX_CTRL_D, 1'b0, 8'h00);
        chk({8'h0, rdv}, 16'h00);
        chk({15'h0, irq}, 16'h0);
        $display("conversion done");
        apb(`TKC_IDX_CTRL_A, 1'b1, 8'h8f);
        n = 0;
        while (wakeup !== 1'b1 && n < 4000) begin
            @(posedge ref_clk);
            n++;
        end
        chk(16'(n >= 2052 && n <= 2064), 16'h1);
        apb(`TKC_IDX_CTRL_D, 1'b0, 8'h00);
        chk({15'h0, rdv[1]}, 16'h1);
        $display("auto done");
        rst_b <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        apb(`TKC_IDX_CTRL_A, 1'b0, 8'h00);
        chk({8'h0, rdv}, 16'h00);
        $display("reset done");
        test_done();
    end
endmodule
